// *** rtl/sensor_alert_offset_regs.sv ***
// Alert enables, result trims, limits and status flags of the sensor
`timescale 1ns/100ps
module sensor_alert_offset_regs (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_WDATA,
   output logic      [7:0]  REG_RDATA,
   input  wire logic [15:0] TEMP_RAW,
   input  wire logic        TEMP_DONE,
   input  wire logic [15:0] HUM_RAW,
   input  wire logic        HUM_DONE,
   output logic [15:0]      TEMP_ADJUSTED,
   output logic [15:0]      HUM_ADJUSTED,
   output logic [7:0]       STATUS_FLAGS,
   output logic             ALERT_OUTPUT_PIN
);
   logic [7:0]  enables_ff;
   logic [7:0]  temperature_trim_ff;
   logic [7:0]  humidity_trim_ff;
   logic [7:0]  temperature_low_limit_ff;
   logic [7:0]  temperature_high_limit_ff;
   logic [7:0]  humidity_low_limit_ff;
   logic [7:0]  humidity_high_limit_ff;
   logic [7:0]  flags_ff;
   logic [7:0]  nxt_flags;
   logic [7:0]  nxt_rdata;
   logic [7:0]  events;
   logic [15:0] temp_adj;
   logic [15:0] hum_adj;
   logic        status_read;

   alert_cmp_if temp_cmp ();
   alert_cmp_if hum_cmp ();

   trim_adder u_temp_trim (
      .raw      (TEMP_RAW),
      .trim     (temperature_trim_ff),
      .adjusted (temp_adj)
   );
   // Humidity step is coarser than the temperature step
   trim_adder #(
      .SHIFT    (alert_regs_pkg::HUM_TRIM_SHIFT)
   ) u_hum_trim (
      .raw      (HUM_RAW),
      .trim     (humidity_trim_ff),
      .adjusted (hum_adj)
   );

   // Upper byte of the trimmed result is what the limits are scaled to
   assign temp_cmp.value      = temp_adj[15:8];
   assign temp_cmp.low_limit  = temperature_low_limit_ff;
   assign temp_cmp.high_limit = temperature_high_limit_ff;
   assign hum_cmp.value       = hum_adj[15:8];
   assign hum_cmp.low_limit   = humidity_low_limit_ff;
   assign hum_cmp.high_limit  = humidity_high_limit_ff;

   limit_compare u_temp_cmp (.port (temp_cmp));
   limit_compare u_hum_cmp (.port (hum_cmp));

   // Writable configuration registers
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         enables_ff                <= alert_regs_pkg::RST_ENABLES;
         temperature_trim_ff       <= alert_regs_pkg::RST_TRIM;
         humidity_trim_ff          <= alert_regs_pkg::RST_TRIM;
         temperature_low_limit_ff  <= alert_regs_pkg::RST_LOW;
         temperature_high_limit_ff <= alert_regs_pkg::RST_HIGH;
         humidity_low_limit_ff     <= alert_regs_pkg::RST_LOW;
         humidity_high_limit_ff    <= alert_regs_pkg::RST_HIGH;
      end else if (REG_WR) begin
         unique case (REG_ADDR)
            alert_regs_pkg::ADDR_ENABLES: begin
               // Reserved low bits are not stored
               enables_ff <= REG_WDATA & alert_regs_pkg::FLAG_MASK;
            end
            alert_regs_pkg::ADDR_TEMP_TRIM: begin
               temperature_trim_ff <= REG_WDATA;
            end
            alert_regs_pkg::ADDR_HUM_TRIM: begin
               humidity_trim_ff <= REG_WDATA;
            end
            alert_regs_pkg::ADDR_TEMP_LOW: begin
               temperature_low_limit_ff <= REG_WDATA;
            end
            alert_regs_pkg::ADDR_TEMP_HIGH: begin
               temperature_high_limit_ff <= REG_WDATA;
            end
            alert_regs_pkg::ADDR_HUM_LOW: begin
               humidity_low_limit_ff <= REG_WDATA;
            end
            alert_regs_pkg::ADDR_HUM_HIGH: begin
               humidity_high_limit_ff <= REG_WDATA;
            end
            default: begin
            end
         endcase
      end
   end

   // Flag events; limits checked only on a finished conversion
   always_comb begin
      events = '0;
      events[alert_regs_pkg::BIT_CONV_DONE]  = TEMP_DONE | HUM_DONE;
      events[alert_regs_pkg::BIT_TEMP_ABOVE] = TEMP_DONE & temp_cmp.above;
      events[alert_regs_pkg::BIT_TEMP_BELOW] = TEMP_DONE & temp_cmp.below;
      events[alert_regs_pkg::BIT_HUM_ABOVE]  = HUM_DONE & hum_cmp.above;
      events[alert_regs_pkg::BIT_HUM_BELOW]  = HUM_DONE & hum_cmp.below;
   end

   assign status_read = REG_RD && (REG_ADDR == alert_regs_pkg::ADDR_STATUS);

   // Read clears, but a same-cycle event is kept so none is lost
   always_comb begin
      nxt_flags = flags_ff;
      if (status_read)
         nxt_flags = '0;
      nxt_flags = nxt_flags | events;
   end

   always_ff @(posedge CLOCK) begin
      if (RST)
         flags_ff <= alert_regs_pkg::RST_STATUS;
      else
         flags_ff <= nxt_flags;
   end

   always_comb begin
      unique case (REG_ADDR)
         alert_regs_pkg::ADDR_STATUS:    nxt_rdata = flags_ff;
         alert_regs_pkg::ADDR_ENABLES:   nxt_rdata = enables_ff;
         alert_regs_pkg::ADDR_TEMP_TRIM: nxt_rdata = temperature_trim_ff;
         alert_regs_pkg::ADDR_HUM_TRIM:  nxt_rdata = humidity_trim_ff;
         alert_regs_pkg::ADDR_TEMP_LOW:  nxt_rdata = temperature_low_limit_ff;
         alert_regs_pkg::ADDR_TEMP_HIGH: nxt_rdata = temperature_high_limit_ff;
         alert_regs_pkg::ADDR_HUM_LOW:   nxt_rdata = humidity_low_limit_ff;
         alert_regs_pkg::ADDR_HUM_HIGH:  nxt_rdata = humidity_high_limit_ff;
         default:                        nxt_rdata = 8'h00;
      endcase
   end

   // Read data registered: valid the cycle after REG_RD
   always_ff @(posedge CLOCK) begin
      if (RST)
         REG_RDATA <= 8'h00;
      else if (REG_RD)
         REG_RDATA <= nxt_rdata;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         TEMP_ADJUSTED <= 16'h0000;
         HUM_ADJUSTED  <= 16'h0000;
      end else begin
         if (TEMP_DONE)
            TEMP_ADJUSTED <= temp_adj;
         if (HUM_DONE)
            HUM_ADJUSTED <= hum_adj;
      end
   end

   // Alert is registered in the same cycle as the flags, gated per source
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         STATUS_FLAGS     <= alert_regs_pkg::RST_STATUS;
         ALERT_OUTPUT_PIN <= 1'b0;
      end else begin
         STATUS_FLAGS     <= nxt_flags;
         ALERT_OUTPUT_PIN <= |(nxt_flags & enables_ff);
      end
   end
endmodule

// *** include/alert_regs_pkg.sv ***
// Constants for the alert, trim and limit register group
//Contract
//- Enable bit 7 gates conversion-done alert generation; resets to 0.
//- Enable bit 6 gates temperature-above alert generation; resets to 0.
//- Enable bit 5 gates temperature-below alert generation; resets to 0.
//- Enable bit 4 gates humidity-above alert generation; resets to 0.
//- Enable bit 3 gates humidity-below alert; bits 2..0 read zero.
//- Temperature trim is added to every converted temperature; resets zero.
//- Temperature trim is signed two's complement, 0.16 degC per step.
//- Humidity trim is added to every converted humidity; resets zero.
//- Humidity trim is signed, 0.20 %RH per step.
//- Temperature low limit, 8-bit writable, resets to zero.
//- Temperature high limit, 8-bit writable, resets to all ones.
//- Humidity low limit, 8-bit writable, resets to zero.
//- Humidity high limit, 8-bit writable, resets to all ones.
//- Threshold flags set when exceeded, cleared by reading status register.
//- Conversion-done flag sets when any conversion finishes.
package alert_regs_pkg;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_ENABLES   = 8'h07;
   localparam logic [7:0] ADDR_TEMP_TRIM = 8'h08;
   localparam logic [7:0] ADDR_HUM_TRIM  = 8'h09;
   localparam logic [7:0] ADDR_TEMP_LOW  = 8'h0a;
   localparam logic [7:0] ADDR_TEMP_HIGH = 8'h0b;
   localparam logic [7:0] ADDR_HUM_LOW   = 8'h0c;
   localparam logic [7:0] ADDR_HUM_HIGH  = 8'h0d;

   localparam int BIT_CONV_DONE  = 7;
   localparam int BIT_TEMP_ABOVE = 6;
   localparam int BIT_TEMP_BELOW = 5;
   localparam int BIT_HUM_ABOVE  = 4;
   localparam int BIT_HUM_BELOW  = 3;
   localparam logic [7:0] FLAG_MASK = 8'hf8;

   localparam logic [7:0] RST_ENABLES = 8'h00;
   localparam logic [7:0] RST_TRIM    = 8'h00;
   localparam logic [7:0] RST_LOW     = 8'h00;
   localparam logic [7:0] RST_HIGH    = 8'hff;
   localparam logic [7:0] RST_STATUS  = 8'h00;

   localparam int RESULT_W = 16;
   localparam int TRIM_W   = 8;
   // Trim LSB lands on result bit 6 (165/2^16*2^6 ~ 0.16 degC)
   localparam int TRIM_SHIFT = 6;
   // Humidity trim LSB lands on result bit 7 (100/2^16*2^7 ~ 0.20 %RH)
   localparam int HUM_TRIM_SHIFT = 7;
endpackage

// *** include/alert_cmp_if.sv ***
// Interface carrying an adjusted result and its limits to a comparator
`timescale 1ns/100ps
interface alert_cmp_if;
   logic [7:0] value;
   logic [7:0] low_limit;
   logic [7:0] high_limit;
   logic       above;
   logic       below;
   modport src (output value, output low_limit, output high_limit,
                input above, input below);
   modport cmp (input value, input low_limit, input high_limit,
                output above, output below);
endinterface

// *** rtl/trim_adder.sv ***
// Adds a signed trim to an unsigned conversion result with saturation
`timescale 1ns/100ps
module trim_adder #(
   parameter int RESULT_W = alert_regs_pkg::RESULT_W,
   parameter int TRIM_W   = alert_regs_pkg::TRIM_W,
   parameter int SHIFT    = alert_regs_pkg::TRIM_SHIFT
) (
   input  wire logic [RESULT_W-1:0] raw,
   input  wire logic [TRIM_W-1:0]   trim,
   output logic      [RESULT_W-1:0] adjusted
);
   if (SHIFT < 0 || SHIFT + TRIM_W > RESULT_W) begin : g_fit_check
      $error("trim_adder: trim does not fit result");
   end
   logic signed [RESULT_W+1:0] sum;
   logic signed [RESULT_W+1:0] trim_ext;
   always_comb begin
      // Sign extend then scale, so all ones is minus one step
      trim_ext = (RESULT_W+2)'($signed(trim)) <<< SHIFT;
      sum = $signed({2'b00, raw}) + trim_ext;
      // Saturate rather than wrap: a wrap would flip high and low alerts
      if (sum < 0)
         adjusted = '0;
      else if (sum[RESULT_W])
         adjusted = '1;
      else
         adjusted = sum[RESULT_W-1:0];
   end
endmodule

// *** rtl/limit_compare.sv ***
// Compares one adjusted result byte against its low and high limits
`timescale 1ns/100ps
module limit_compare (
   alert_cmp_if.cmp port
);
   assign port.above = port.value > port.high_limit;
   assign port.below = port.value < port.low_limit;
endmodule

// *** testbench/host_model.sv ***
// Host model issuing single-byte register writes and reads
`timescale 1ns/100ps
module host_model (
   input  wire logic       clock,
   output logic      [7:0] addr,
   output logic            wr,
   output logic            rd,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata
);
   initial begin
      {addr, wdata, wr, rd} = 18'h0;
   end
   task automatic xfer(logic w, logic [7:0] a, logic [7:0] d,
                       output logic [7:0] q);
      @(negedge clock);
      {addr, wdata, wr, rd} = {a, d, w, !w};
      @(negedge clock);
      q = rdata;
      // Idle address and data lines carry inverted values, never stale ones; wr and rd go low
      {addr, wdata, wr, rd} = {~a, ~d, 2'b00};
   endtask
endmodule

// *** testbench/sensor_alert_offset_regs_checker.sv ***
// Port assertions for the alert register group
`timescale 1ns/100ps
module sensor_alert_offset_regs_checker (
   input wire logic        CLOCK,
   input wire logic        RST,
   input wire logic [7:0]  REG_ADDR,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_WDATA,
   input wire logic [7:0]  REG_RDATA,
   input wire logic [15:0] TEMP_RAW,
   input wire logic        TEMP_DONE,
   input wire logic [15:0] HUM_RAW,
   input wire logic        HUM_DONE,
   input wire logic [15:0] TEMP_ADJUSTED,
   input wire logic [15:0] HUM_ADJUSTED,
   input wire logic [7:0]  STATUS_FLAGS,
   input wire logic        ALERT_OUTPUT_PIN
);
   wire ev = TEMP_DONE || HUM_DONE;
   wire st_rd = REG_RD && REG_ADDR == alert_regs_pkg::ADDR_STATUS;
   wire en_rd = REG_RD && REG_ADDR == alert_regs_pkg::ADDR_ENABLES;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   property p_rsv; en_rd |=> REG_RDATA[2:0] == 3'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_done; ev |=> STATUS_FLAGS[7]; endproperty
   a_done: assert property (p_done) else $error("done flag low");
   property p_clr; st_rd && !ev |=> STATUS_FLAGS == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("flags kept");
   property p_hold; !ev && !st_rd |=> $stable(STATUS_FLAGS); endproperty
   a_hold: assert property (p_hold) else $error("flags moved");
   property p_tadj; !TEMP_DONE |=> $stable(TEMP_ADJUSTED); endproperty
   a_tadj: assert property (p_tadj) else $error("temp moved");
   property p_hadj; !HUM_DONE |=> $stable(HUM_ADJUSTED); endproperty
   a_hadj: assert property (p_hadj) else $error("hum moved");
   property p_thi; $rose(STATUS_FLAGS[6]) |-> $past(TEMP_DONE); endproperty
   a_thi: assert property (p_thi) else $error("temp flag");
   property p_hlo; $rose(STATUS_FLAGS[3]) |-> $past(HUM_DONE); endproperty
   a_hlo: assert property (p_hlo) else $error("hum flag");
   // Enable writes may take two cycles to reach the pin
   property p_alert; $rose(ALERT_OUTPUT_PIN) |->
      $past(ev) || $past(REG_WR) || $past(REG_WR, 2); endproperty
   a_alert: assert property (p_alert) else $error("alert cause");
   c_alert: cover property (ev ##1 ALERT_OUTPUT_PIN);
   c_clr: cover property (st_rd ##1 STATUS_FLAGS == 8'h00);
   c_hum: cover property (STATUS_FLAGS[4]);
endmodule
bind sensor_alert_offset_regs sensor_alert_offset_regs_checker chk (
   .CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .TEMP_RAW(TEMP_RAW), .TEMP_DONE(TEMP_DONE), .HUM_RAW(HUM_RAW),
   .HUM_DONE(HUM_DONE), .TEMP_ADJUSTED(TEMP_ADJUSTED),
   .HUM_ADJUSTED(HUM_ADJUSTED), .STATUS_FLAGS(STATUS_FLAGS),
   .ALERT_OUTPUT_PIN(ALERT_OUTPUT_PIN));

// *** testbench/sensor_alert_offset_regs_tb.sv ***
// Self-checking bench with a reference model of the register group
`timescale 1ns/100ps
module sensor_alert_offset_regs_tb;
   logic        clock, rst, wr, rd, t_done, h_done, alert;
   logic [7:0]  addr, wdata, rdata, flags, q, exp_fl;
   logic [15:0] t_raw, h_raw, t_adj, h_adj;
   logic [7:0]  regs [7:13];
   int          fail_count, total_checks, cycles;
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   sensor_alert_offset_regs dut (.CLOCK(clock), .RST(rst), .REG_ADDR(addr),
      .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .TEMP_RAW(t_raw), .TEMP_DONE(t_done), .HUM_RAW(h_raw),
      .HUM_DONE(h_done), .TEMP_ADJUSTED(t_adj), .HUM_ADJUSTED(h_adj),
      .STATUS_FLAGS(flags), .ALERT_OUTPUT_PIN(alert));
   host_model host (.clock(clock), .addr(addr), .wr(wr), .rd(rd),
      .wdata(wdata), .rdata(rdata));
   task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: byte %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk_res(logic [15:0] got, logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: result %h not %h", $time, got, exp);
      end
   endtask
   // Trim step sits on result bit sh; clamps at both ends
   function automatic logic [15:0] adj(logic [15:0] r, logic [7:0] t,
                                       int sh);
      int v;
      v = int'(r) + int'($signed(t)) * (1 << sh);
      return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : 16'(v);
   endfunction
   task automatic reg_rd(logic [7:0] a);
      logic [7:0] e;
      e = (a == 8'h04) ? exp_fl : (a > 8'h06 && a < 8'h0e) ? regs[a] : 8'h00;
      host.xfer(1'b0, a, 8'h00, q);
      chk_reg(q, e);
      if (a == 8'h04) exp_fl = 8'h00;
   endtask
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      host.xfer(1'b1, a, d, q);
      if (a > 8'h06 && a < 8'h0e) regs[a] = (a == 8'h07) ? d & 8'hf8 : d;
   endtask
   task automatic convert();
      logic [15:0] et, eh;
      @(negedge clock);
      t_raw = 16'($urandom);
      h_raw = 16'($urandom);
      {t_done, h_done} = 2'b11;
      et = adj(t_raw, regs[8], alert_regs_pkg::TRIM_SHIFT);
      eh = adj(h_raw, regs[9], alert_regs_pkg::HUM_TRIM_SHIFT);
      exp_fl |= {1'b1, et[15:8] > regs[11], et[15:8] < regs[10],
                 eh[15:8] > regs[13], eh[15:8] < regs[12], 3'b000};
      @(negedge clock);
      {t_done, h_done} = 2'b00;
      chk_res(t_adj, et);
      chk_res(h_adj, eh);
      chk_reg(flags, exp_fl);
      chk_reg({7'h0, alert}, {7'h0, |(exp_fl & regs[7])});
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end
   initial begin
      {rst, t_done, h_done, t_raw, h_raw, exp_fl} = {3'b100, 40'h0};
      fail_count = 0;
      total_checks = 0;
      cycles = 0;
      regs = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff};
      void'($urandom(32'h33538244));
      repeat (8) @(negedge clock);
      rst = 1'b0;
      for (int a = 3; a < 15; a++) reg_rd(8'(a));
      $display("test reset values done");
      for (int a = 3; a < 15; a++) begin
         wr_reg(8'(a), 8'($urandom));
         reg_rd(8'(a));
      end
      $display("test write readback done");
      for (int i = 0; i < 40; i++) begin
         for (int a = 7; a < 14; a++) wr_reg(8'(a), 8'($urandom));
         convert();
         if (i[0]) reg_rd(8'h04);
      end
      $display("test conversions done");
      // Reset in mid-run must drop flags, results and settings
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      chk_res(t_adj, 16'h0000);
      chk_res(h_adj, 16'h0000);
      chk_reg(flags, 8'h00);
      chk_reg({7'h0, alert}, 8'h00);
      regs = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff};
      exp_fl = 8'h00;
      for (int a = 3; a < 15; a++) reg_rd(8'(a));
      $display("test mid-run reset done");
      print_verdict();
   end
endmodule
